/* sbpio_defines.svh */
// Purpose: constants for the shared bus pin I/O ports
// Assumes: registers decoded on the full 32-bit byte address
// Notes: bit vectors inside the block are in pin order, index n = register bit n
`ifndef SBPIO_DEFINES_SVH
`define SBPIO_DEFINES_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SBPIO_ADR_AB_ASSIGN 32'h8007_FC84
`define SBPIO_ADR_AB_DATA 32'h8007_FC88
`define SBPIO_ADR_CTL_DIR 32'h8007_FC98
`define SBPIO_ADR_CTL_ASSIGN 32'h8007_FC9C
`define SBPIO_ADR_CTL_DATA 32'h8007_FCA0

// ----------------------------------------
// field masks and reset values, pin order
// ----------------------------------------
`define SBPIO_CTL_IMPL_MASK 32'hFCFF_FEFF
`define SBPIO_AB_RST_FIXED 12'hFFF
`define SBPIO_CTL_DIR_RST 32'h0000_0000
`define SBPIO_HALF_ZERO 16'h0000
`define SBPIO_WORD_ZERO 32'h0000_0000

`endif

/* sbpio_pkg.sv */
// Purpose: shared types for the shared bus pin I/O ports
// Assumes: nothing
// Notes: constants live in sbpio_defines.svh
package sbpio_pkg;
  typedef logic [31:0] sbpio_word_t;
  typedef logic [15:0] sbpio_half_t;
  typedef logic [3:0] sbpio_nib_t;
endpackage

/* sbpio_addr_port.sv */
// Purpose: port A/B pin drivers, address bus or output-only I/O
// Assumes: chip-select logic leaves the pins in non-chip-select use
// Notes: pin n carries address bit n when in bus use
`timescale 1ns/1ps
`default_nettype none

module sbpio_addr_port
  import sbpio_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // control
  input wire sbpio_pkg::sbpio_half_t i_assign,
  input wire sbpio_pkg::sbpio_half_t i_data,
  input wire sbpio_pkg::sbpio_half_t i_bus_addr,
  // pins
  output var sbpio_pkg::sbpio_half_t o_pin
);

  genvar g;

  // ----------------------------------------
  // per pin multiplexer
  // ----------------------------------------
  generate
    for (g = 0; g < 16; g++)
    begin : g_pin
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_b)
          o_pin[g] <= 1'b0;
        else if (i_assign[g])
          o_pin[g] <= i_bus_addr[g];
        else
          o_pin[g] <= i_data[g];
      end
    end
  endgenerate

  property p_addr_bus;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_assign == 16'hFFFF |=> o_pin == $past(i_bus_addr);
  endproperty
  a_addr_bus: assert property (p_addr_bus) else $error("address pins miss bus value");

  property p_addr_io;
    @(posedge i_clk) disable iff (!i_rst_b)
    (!i_assign[0] && !i_assign[15]) |=> o_pin[0] == $past(i_data[0])
      && o_pin[15] == $past(i_data[15]);
  endproperty
  a_addr_io: assert property (p_addr_io) else $error("port pin misses data value");

endmodule

`default_nettype wire

/* sbpio_ctrl_port.sv */
// Purpose: port I/J/K/L pin drivers, bus control or bidirectional I/O
// Assumes: bus side supplies its own drive and enable per pin
// Notes: output enables are active low; unimplemented pins stay undriven
`timescale 1ns/1ps
`default_nettype none
`include "sbpio_defines.svh"

module sbpio_ctrl_port
  import sbpio_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // control
  input wire sbpio_pkg::sbpio_word_t i_assign,
  input wire sbpio_pkg::sbpio_word_t i_dir,
  input wire sbpio_pkg::sbpio_word_t i_latch,
  input wire sbpio_pkg::sbpio_word_t i_bus_out,
  input wire sbpio_pkg::sbpio_word_t i_bus_oe_b,
  // pins
  output var sbpio_pkg::sbpio_word_t o_pin_out,
  output var sbpio_pkg::sbpio_word_t o_pin_oe_b
);

  // a named copy, since a bit cannot be picked out of a bare literal
  localparam sbpio_word_t impl_mask = `SBPIO_CTL_IMPL_MASK;
  genvar g;

  // ----------------------------------------
  // per pin function and direction
  // ----------------------------------------
  generate
    for (g = 0; g < 32; g++)
    begin : g_pin
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_b)
        begin
          o_pin_out[g] <= 1'b0;
          o_pin_oe_b[g] <= 1'b1;
        end
        else if (!impl_mask[g])
        begin
          o_pin_out[g] <= 1'b0;
          o_pin_oe_b[g] <= 1'b1;
        end
        else if (i_assign[g])
        begin
          // bus vector order matches pin order
          o_pin_out[g] <= i_bus_out[g];
          o_pin_oe_b[g] <= i_bus_oe_b[g];
        end
        else
        begin
          o_pin_out[g] <= i_latch[g];
          o_pin_oe_b[g] <= !i_dir[g];
        end
      end
    end
  endgenerate

  property p_io_out;
    @(posedge i_clk) disable iff (!i_rst_b)
    (!i_assign[0] && i_dir[0]) |=> !o_pin_oe_b[0] && o_pin_out[0] == $past(i_latch[0]);
  endproperty
  a_io_out: assert property (p_io_out) else $error("output pin not driven from latch");

  property p_io_in;
    @(posedge i_clk) disable iff (!i_rst_b)
    (!i_assign[31] && !i_dir[31]) |=> o_pin_oe_b[31];
  endproperty
  a_io_in: assert property (p_io_in) else $error("input pin is driven");

  property p_bus_fn;
    @(posedge i_clk) disable iff (!i_rst_b)
    i_assign[16] |=> o_pin_out[16] == $past(i_bus_out[16])
      && o_pin_oe_b[16] == $past(i_bus_oe_b[16]);
  endproperty
  a_bus_fn: assert property (p_bus_fn) else $error("bus function not on pin");

endmodule

`default_nettype wire

/* sbpio_top.sv */
// Purpose: register file and pin control for the shared bus pin I/O ports
// Assumes: one 125 MHz clock, synchronous active-low reset, inputs synchronous
// Notes: data latches have no reset, so pins in I/O output use show X until written
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sbpio_defines.svh"

module sbpio_top
  import sbpio_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // reset configuration word fields
  input wire sbpio_pkg::sbpio_nib_t I_CFG_AB_ASSIGN,
  input wire sbpio_pkg::sbpio_word_t I_CFG_CTL_ASSIGN,
  // register port
  input wire sbpio_pkg::sbpio_word_t I_ADDR,
  input wire sbpio_pkg::sbpio_word_t I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output var sbpio_pkg::sbpio_word_t O_RDATA,
  // bus interface side
  input wire sbpio_pkg::sbpio_half_t I_BUS_ADDR,
  input wire sbpio_pkg::sbpio_word_t I_BUS_CTL_OUT,
  input wire sbpio_pkg::sbpio_word_t I_BUS_CTL_OE_B,
  output var sbpio_pkg::sbpio_word_t O_BUS_CTL_IN,
  // pins
  output var sbpio_pkg::sbpio_half_t O_ADDR_PIN,
  input wire sbpio_pkg::sbpio_word_t I_CTL_PIN_IN,
  output var sbpio_pkg::sbpio_word_t O_CTL_PIN_OUT,
  output var sbpio_pkg::sbpio_word_t O_CTL_PIN_OE_B
);

  import sbpio_pkg::*;

  // ----------------------------------------
  // registers, all held in pin order
  // ----------------------------------------
  sbpio_half_t ab_assign_q;
  sbpio_half_t ab_data_q;
  sbpio_word_t dir_q;
  sbpio_word_t ctl_assign_q;
  sbpio_word_t ctl_latch_q;
  sbpio_word_t rdata_d;
  sbpio_word_t wr_pin;
  sbpio_word_t data_view;
  logic sel_ab_assign;
  logic sel_ab_data;
  logic sel_dir;
  logic sel_ctl_assign;
  logic sel_ctl_data;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // software sees register bit 0 as the word msb, so words are bit-reversed
  assign wr_pin = {<<{I_WDATA}};
  assign sel_ab_assign = (I_ADDR == `SBPIO_ADR_AB_ASSIGN);
  assign sel_ab_data = (I_ADDR == `SBPIO_ADR_AB_DATA);
  assign sel_dir = (I_ADDR == `SBPIO_ADR_CTL_DIR);
  assign sel_ctl_assign = (I_ADDR == `SBPIO_ADR_CTL_ASSIGN);
  assign sel_ctl_data = (I_ADDR == `SBPIO_ADR_CTL_DATA);

  // ----------------------------------------
  // port A/B assignment and data
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      ab_assign_q <= {I_CFG_AB_ASSIGN, `SBPIO_AB_RST_FIXED};
    else if (I_WR && sel_ab_assign)
      ab_assign_q <= wr_pin[15:0];
  end

  // output-only data, not reset
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_WR && sel_ab_data)
      ab_data_q <= wr_pin[15:0];
  end

  // ----------------------------------------
  // port I..L direction and assignment
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      dir_q <= `SBPIO_CTL_DIR_RST;
    else if (I_WR && sel_dir)
      dir_q <= wr_pin & `SBPIO_CTL_IMPL_MASK;
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      ctl_assign_q <= I_CFG_CTL_ASSIGN & `SBPIO_CTL_IMPL_MASK;
    else if (I_WR && sel_ctl_assign)
      ctl_assign_q <= wr_pin & `SBPIO_CTL_IMPL_MASK;
  end

  // ----------------------------------------
  // port I..L data latches
  // ----------------------------------------
  // no reset term on purpose: contents survive reset until written
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_WR && sel_ctl_data)
      ctl_latch_q <= wr_pin & `SBPIO_CTL_IMPL_MASK;
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // pins in I/O input use show the live level, all others the latch
  assign data_view = ((~ctl_assign_q & ~dir_q & I_CTL_PIN_IN)
    | ((ctl_assign_q | dir_q) & ctl_latch_q)) & `SBPIO_CTL_IMPL_MASK;

  always_comb
  begin
    rdata_d = `SBPIO_WORD_ZERO;
    case (1'b1)
      sel_ab_assign: rdata_d = {<<{{`SBPIO_HALF_ZERO, ab_assign_q}}};
      sel_ab_data: rdata_d = {<<{{`SBPIO_HALF_ZERO, ab_data_q}}};
      sel_dir: rdata_d = {<<{dir_q}};
      sel_ctl_assign: rdata_d = {<<{ctl_assign_q}};
      sel_ctl_data: rdata_d = {<<{data_view}};
      default: rdata_d = `SBPIO_WORD_ZERO;
    endcase
  end

  // data stand one cycle only, zero otherwise
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      O_RDATA <= `SBPIO_WORD_ZERO;
    else if (I_RD)
      O_RDATA <= rdata_d;
    else
      O_RDATA <= `SBPIO_WORD_ZERO;
  end

  // ----------------------------------------
  // pin level returned to the bus interface
  // ----------------------------------------
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_B)
      O_BUS_CTL_IN <= `SBPIO_WORD_ZERO;
    else
      O_BUS_CTL_IN <= I_CTL_PIN_IN & ctl_assign_q;
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  sbpio_addr_port u_addr_port (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_assign(ab_assign_q),
    .i_data(ab_data_q),
    .i_bus_addr(I_BUS_ADDR),
    .o_pin(O_ADDR_PIN)
  );

  sbpio_ctrl_port u_ctrl_port (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_assign(ctl_assign_q),
    .i_dir(dir_q),
    .i_latch(ctl_latch_q),
    .i_bus_out(I_BUS_CTL_OUT),
    .i_bus_oe_b(I_BUS_CTL_OE_B),
    .o_pin_out(O_CTL_PIN_OUT),
    .o_pin_oe_b(O_CTL_PIN_OE_B)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // helper only: write data in pin order, built apart from the decode path
  sbpio_word_t wdata_rev;
  // helper only: unknown until the first data write, so the keep check waits for it
  logic latch_known_q;
  genvar k;

  generate
    for (k = 0; k < 32; k++)
    begin : g_rev
      assign wdata_rev[k] = I_WDATA[31 - k];
    end
  endgenerate

  always_ff @(posedge I_CORE_CLK)
  begin
    latch_known_q <= latch_known_q | (I_WR && sel_ctl_data);
  end

  property p_reset_assign;
    @(posedge I_CORE_CLK)
    !I_RST_B |=> ab_assign_q[11:0] == `SBPIO_AB_RST_FIXED
      && ab_assign_q[15:12] == $past(I_CFG_AB_ASSIGN);
  endproperty
  a_reset_assign: assert property (p_reset_assign) else $error("A/B assign reset wrong");

  property p_reset_ctl_assign;
    @(posedge I_CORE_CLK)
    !I_RST_B |=> ctl_assign_q == ($past(I_CFG_CTL_ASSIGN) & `SBPIO_CTL_IMPL_MASK)
      && dir_q == `SBPIO_CTL_DIR_RST;
  endproperty
  a_reset_ctl_assign: assert property (p_reset_ctl_assign) else $error("I..L reset wrong");

  property p_latch_write;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_WR && I_ADDR == `SBPIO_ADR_CTL_DATA)
      |=> ctl_latch_q == ($past(wdata_rev) & `SBPIO_CTL_IMPL_MASK);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("data write not latched");

  property p_latch_keep;
    @(posedge I_CORE_CLK)
    (latch_known_q && (!I_WR || I_ADDR != `SBPIO_ADR_CTL_DATA))
      |=> ctl_latch_q == $past(ctl_latch_q);
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch changed without write");

  property p_read_input;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_RD && I_ADDR == `SBPIO_ADR_CTL_DATA && !ctl_assign_q[0] && !dir_q[0])
      |=> O_RDATA[31] == $past(I_CTL_PIN_IN[0]);
  endproperty
  a_read_input: assert property (p_read_input) else $error("input read not pin level");

  property p_read_output;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_RD && I_ADDR == `SBPIO_ADR_CTL_DATA && dir_q[1])
      |=> O_RDATA[30] == $past(ctl_latch_q[1]);
  endproperty
  a_read_output: assert property (p_read_output) else $error("output read not latch");

  property p_unimpl_zero;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    I_RD |=> O_RDATA[23] == 1'b0 || $past(I_ADDR) == `SBPIO_ADR_AB_ASSIGN
      || $past(I_ADDR) == `SBPIO_ADR_AB_DATA;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("bit 8 reads nonzero");

  property p_reserved_zero;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_RD && I_ADDR == `SBPIO_ADR_AB_ASSIGN) |=> O_RDATA[15:0] == `SBPIO_HALF_ZERO
      && O_RDATA[31] == $past(ab_assign_q[0]) && O_RDATA[16] == $past(ab_assign_q[15]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("A/B assign read wrong");

  property p_dir_write;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_WR && I_ADDR == `SBPIO_ADR_CTL_DIR)
      |=> dir_q == ($past(wdata_rev) & `SBPIO_CTL_IMPL_MASK);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_assign_write;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_WR && I_ADDR == `SBPIO_ADR_CTL_ASSIGN)
      |=> ctl_assign_q == ($past(wdata_rev) & `SBPIO_CTL_IMPL_MASK);
  endproperty
  a_assign_write: assert property (p_assign_write) else $error("assign write lost");

  property p_ab_data_write;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    (I_WR && I_ADDR == `SBPIO_ADR_AB_DATA) |=> ab_data_q == $past(wdata_rev[15:0]);
  endproperty
  a_ab_data_write: assert property (p_ab_data_write) else $error("A/B data write lost");

  property p_io_hidden;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    !ctl_assign_q[5] |=> !O_BUS_CTL_IN[5];
  endproperty
  a_io_hidden: assert property (p_io_hidden) else $error("I/O pin level seen by bus");

  property p_unimpl_regs;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    !dir_q[8] && !dir_q[25] && !ctl_assign_q[8] && !ctl_assign_q[24];
  endproperty
  a_unimpl_regs: assert property (p_unimpl_regs) else $error("unimplemented bit set");

  property p_read_one_cycle;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    !I_RD |=> O_RDATA == `SBPIO_WORD_ZERO;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data held too long");

  property p_addr_path;
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    ab_assign_q[3] ##1 ab_assign_q[3] |-> O_ADDR_PIN[3] == $past(I_BUS_ADDR[3]);
  endproperty
  a_addr_path: assert property (p_addr_path) else $error("pin 3 not address bit 3");

endmodule

`default_nettype wire

/* sbpio_pin_model.sv */
// Purpose: far side of the port I..L pins, works out the wire level
// Assumes: design enables are active low
// Notes: a released pin with no outside driver toggles every cycle
`timescale 1ns/1ps
`default_nettype none

module sbpio_pin_model
  import sbpio_pkg::*;
(
  // clock
  input wire logic i_clk,
  // design side
  input wire sbpio_pkg::sbpio_word_t i_out,
  input wire sbpio_pkg::sbpio_word_t i_oe_b,
  // outside driver
  input wire sbpio_pkg::sbpio_word_t i_ext,
  input wire sbpio_pkg::sbpio_word_t i_ext_en,
  // wire level
  output var sbpio_pkg::sbpio_word_t o_pin
);
  logic tgl_q = 1'b0;

  always @(posedge i_clk)
    tgl_q <= ~tgl_q;

  // a floating line must never hold a stale level, so it wanders instead
  assign o_pin = (~i_oe_b & i_out) | (i_oe_b & i_ext_en & i_ext)
    | (i_oe_b & ~i_ext_en & {32{tgl_q}});
endmodule

`default_nettype wire

/* sbpio_tb_top.sv */
// Purpose: self-checking bench for the shared bus pin I/O ports
// Assumes: register reads answer one cycle after the strobe
// Notes: pin checks mask undriven lines, whose drive value is free
`timescale 1ns/1ps
`default_nettype none
`include "sbpio_defines.svh"

module sbpio_tb_top;
  import sbpio_pkg::*;
  localparam sbpio_word_t MSK = `SBPIO_CTL_IMPL_MASK;
  logic clk, rst_b, wr, rd, rd_seen;
  sbpio_nib_t cfg_ab;
  sbpio_word_t cfg_ctl, addr, wdata, rdata, bus_out, bus_oe_b, bus_in;
  sbpio_word_t pin_in, pin_out, pin_oe_b, ext, ext_en;
  sbpio_half_t bus_addr, addr_pin;
  sbpio_word_t exp_q[$];
  int error_cnt, checked;

  sbpio_top dut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CFG_AB_ASSIGN(cfg_ab),
    .I_CFG_CTL_ASSIGN(cfg_ctl), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_BUS_ADDR(bus_addr), .I_BUS_CTL_OUT(bus_out),
    .I_BUS_CTL_OE_B(bus_oe_b), .O_BUS_CTL_IN(bus_in), .O_ADDR_PIN(addr_pin),
    .I_CTL_PIN_IN(pin_in), .O_CTL_PIN_OUT(pin_out), .O_CTL_PIN_OE_B(pin_oe_b));

  sbpio_pin_model pins (.i_clk(clk), .i_out(pin_out), .i_oe_b(pin_oe_b), .i_ext(ext),
    .i_ext_en(ext_en), .o_pin(pin_in));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  function automatic sbpio_word_t rv(input sbpio_word_t x);
    rv = {<<{x}};
  endfunction

  function automatic sbpio_half_t rv16(input sbpio_half_t x);
    rv16 = {<<{x}};
  endfunction

  task automatic chk(input sbpio_word_t seen, input sbpio_word_t exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
    rd_seen <= rd;

  always @(negedge clk)
    if (rd_seen === 1'b1)
      chk(rdata, exp_q.pop_front());

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic wr_reg(input sbpio_word_t a, input sbpio_word_t d);
    @(posedge clk);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
  endtask

  task automatic rd_reg(input sbpio_word_t a, input sbpio_word_t e);
    @(posedge clk);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    exp_q.push_back(e);
  endtask

  task automatic idle(input int n);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset(input sbpio_nib_t ca, input sbpio_word_t cc);
    cfg_ab <= ca;
    cfg_ctl <= cc;
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(`SBPIO_ADR_AB_ASSIGN, {rv16({ca, `SBPIO_AB_RST_FIXED}), `SBPIO_HALF_ZERO});
    rd_reg(`SBPIO_ADR_CTL_DIR, `SBPIO_CTL_DIR_RST);
    rd_reg(`SBPIO_ADR_CTL_ASSIGN, rv(cc & MSK));
    idle(1);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    #(8 * 5000);
    error_cnt++;
    final_report();
  end

  initial
  begin
    sbpio_word_t s, a, d, asg, dir, lat, oe, out, pin;
    sbpio_half_t ha, hd;
    {rst_b, wr, rd, addr, wdata, bus_addr} = '0;
    {bus_out, bus_oe_b, ext, ext_en} = '0;
    s = $urandom(9739);
    s = $urandom();
    do_reset(s[3:0], $urandom());
    // back-to-back writes and reads, with a junk low half
    repeat (4)
    begin
      a = $urandom();
      d = $urandom();
      s = $urandom();
      // data first, so no pin falls back to a never-written data bit
      wr_reg(`SBPIO_ADR_AB_DATA, d);
      wr_reg(`SBPIO_ADR_AB_ASSIGN, a);
      rd_reg(`SBPIO_ADR_AB_ASSIGN, {a[31:16], `SBPIO_HALF_ZERO});
      rd_reg(`SBPIO_ADR_AB_DATA, {d[31:16], `SBPIO_HALF_ZERO});
      bus_addr <= s[15:0];
      idle(3);
      @(negedge clk);
      ha = rv16(a[31:16]);
      hd = rv16(d[31:16]);
      chk({`SBPIO_HALF_ZERO, addr_pin}, {`SBPIO_HALF_ZERO, (ha & bus_addr) | (~ha & hd)});
    end
    ext_en <= 32'hFFFF_FFFF;
    repeat (6)
    begin
      lat = $urandom();
      dir = $urandom();
      asg = $urandom();
      wr_reg(`SBPIO_ADR_CTL_DATA, lat);
      wr_reg(`SBPIO_ADR_CTL_DIR, dir);
      wr_reg(`SBPIO_ADR_CTL_ASSIGN, asg);
      bus_out <= $urandom();
      bus_oe_b <= $urandom();
      ext <= $urandom();
      idle(3);
      @(negedge clk);
      asg = rv(asg) & MSK;
      dir = rv(dir) & MSK;
      lat = rv(lat) & MSK;
      oe = ~MSK | (asg & bus_oe_b) | (~asg & ~dir);
      out = (asg & bus_out) | (~asg & lat);
      pin = (~oe & out) | (oe & ext);
      chk(pin_oe_b, oe);
      chk(pin_out & ~oe, out & ~oe);
      chk(bus_in, asg & pin);
      rd_reg(`SBPIO_ADR_CTL_DIR, rv(dir));
      rd_reg(`SBPIO_ADR_CTL_ASSIGN, rv(asg));
      rd_reg(`SBPIO_ADR_CTL_DATA, rv(MSK & ((~asg & ~dir & pin) | ((asg | dir) & lat))));
      idle(2);
    end
    // second reset in mid-run: every implemented pin to bus use, so reads show the latches
    ext_en <= '0;
    s = $urandom();
    bus_addr <= s[15:0];
    do_reset(4'hF, 32'hFFFF_FFFF);
    rd_reg(`SBPIO_ADR_CTL_DATA, rv(lat));
    wr_reg(32'h8007_FC8C, $urandom());
    rd_reg(32'h8007_FC8C, `SBPIO_WORD_ZERO);
    rd_reg(32'h8007_FCA4, `SBPIO_WORD_ZERO);
    idle(3);
    @(negedge clk);
    chk({`SBPIO_HALF_ZERO, addr_pin}, {`SBPIO_HALF_ZERO, bus_addr});
    final_report();
  end
endmodule

`default_nettype wire
